// ==== dpc_pkg.sv ====
/*
 * Package for the dual-port RAM port controller: pin group structs, states and timing counts.
 * Assumes a 10 MHz core clock; the RAM outside is an asynchronous 2K x 16 dual-port part.
 */
package dpc_pkg;
    localparam int CLK_PERIOD_NS   = 100;
    localparam int ADDR_W          = 11;
    localparam int DATA_W          = 16;
    // Settle time given to the contention flag before a write strobe falls.
    localparam int FLAG_SETTLE_NS  = 40;
    localparam int FLAG_SETTLE_CYC = (FLAG_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Strobe hold after the contention flag has released.
    localparam int WRITE_HOLD_AFTER_FLAG_NS  = 30;
    localparam int WRITE_HOLD_AFTER_FLAG_CYC =
        (WRITE_HOLD_AFTER_FLAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Width of the strobe overlap used for a write or a read.
    localparam int STROBE_NS  = 100;
    localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] CNT_ZERO = 4'h0;

    typedef enum logic [2:0] {
        DPC_IDLE,
        DPC_SETUP,
        DPC_SETTLE,
        DPC_STROBE,
        DPC_HOLD,
        DPC_DONE
    } dpc_state_e;

    typedef struct packed {
        logic              select_n;
        logic              lower_byte_we_n;
        logic              upper_byte_we_n;
        logic              out_en_n;
        logic [ADDR_W-1:0] addr;
    } dpc_pins_s;

    typedef struct packed {
        logic              write;
        logic              lower_byte;
        logic              upper_byte;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } dpc_req_s;
endpackage : dpc_pkg

// ==== dpc_port_ctrl.sv ====
/*
 * Controller that drives one port of the dual-port RAM through its select, byte write strobes,
 * output enable, address and data pins, and watches that port's active-low contention flag.
 * Assumes pins are synchronous to CORE_CLK_I and the flag is pulled up outside.
 */
// How it works
// - Address changes only while select and write strobes are high.
// - Lower and upper byte strobes follow the request byte flags.
// - Contention flags may be ORed into an interrupt by the system.
// - Slave flag inputs are held high for normal operation.
// - One master drives the flags; slaves use them as inhibits.
// - Write starts after the flag settles and holds past its release.
// - Strobe is delayed by the master's maximum arbitration time.
`timescale 1ns/1ps
`default_nettype none
module dpc_port_ctrl (
    input  wire logic                       CORE_CLK_I,
    input  wire logic                       RSTN_I,
    input  wire logic                       REQ_VALID_I,
    input  wire dpc_pkg::dpc_req_s          REQ_I,
    output var  logic                       REQ_READY_O,
    output var  logic                       DONE_O,
    output var  logic [dpc_pkg::DATA_W-1:0] RDATA_O,
    output var  logic                       FLAGGED_O,
    output var  dpc_pkg::dpc_pins_s         PINS_O,
    input  wire logic [dpc_pkg::DATA_W-1:0] DQ_I,
    output var  logic [dpc_pkg::DATA_W-1:0] DQ_O,
    output var  logic                       DQ_OE_O,
    input  wire logic                       CONTENTION_FLAG_N_I
);
    localparam logic [3:0] SETTLE_LD = 4'(dpc_pkg::FLAG_SETTLE_CYC);
    localparam logic [3:0] STROBE_LD = 4'(dpc_pkg::STROBE_CYC);
    localparam logic [3:0] HOLD_LD   = 4'(dpc_pkg::WRITE_HOLD_AFTER_FLAG_CYC);

    dpc_pkg::dpc_state_e              state_reg, state_next;
    logic [3:0]                       cnt_reg, cnt_next;
    dpc_pkg::dpc_req_s                req_reg, req_next;
    dpc_pkg::dpc_pins_s               pins_reg, pins_next;
    logic [dpc_pkg::DATA_W-1:0]       rdata_reg, rdata_next;
    logic                             oe_reg, oe_next;
    logic                             ready_reg, ready_next;
    logic                             done_reg, done_next;
    logic                             flagged_reg, flagged_next;
    logic                             seen_reg, seen_next;

    function automatic dpc_pkg::dpc_pins_s idle_pins(input logic [dpc_pkg::ADDR_W-1:0] a);
        dpc_pkg::dpc_pins_s p;
        p.select_n        = 1'b1;
        p.lower_byte_we_n = 1'b1;
        p.upper_byte_we_n = 1'b1;
        p.out_en_n        = 1'b1;
        p.addr            = a;
        return p;
    endfunction : idle_pins

    always_comb begin
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        req_next     = req_reg;
        pins_next    = pins_reg;
        rdata_next   = rdata_reg;
        oe_next      = oe_reg;
        ready_next   = 1'b0;
        done_next    = 1'b0;
        flagged_next = flagged_reg;
        seen_next    = seen_reg;
        case (state_reg)
            dpc_pkg::DPC_IDLE: begin
                ready_next = 1'b1;
                pins_next  = idle_pins(pins_reg.addr);
                if (REQ_VALID_I && ready_reg) begin
                    req_next   = REQ_I;
                    ready_next = 1'b0;
                    // Address moves with select and strobes high.
                    pins_next  = idle_pins(REQ_I.addr);
                    state_next = dpc_pkg::DPC_SETUP;
                end
            end
            dpc_pkg::DPC_SETUP: begin
                // Select falls first; the strobe only falls later.
                pins_next.select_n = 1'b0;
                pins_next.out_en_n = req_reg.write;
                oe_next            = req_reg.write;
                seen_next          = 1'b0;
                flagged_next       = 1'b0;
                cnt_next           = SETTLE_LD;
                state_next         = dpc_pkg::DPC_SETTLE;
            end
            dpc_pkg::DPC_SETTLE: begin
                // Wait out the master's arbitration before any write strobe.
                if (cnt_reg != dpc_pkg::CNT_ZERO) begin
                    cnt_next = cnt_reg - 4'h1;
                end else begin
                    pins_next.lower_byte_we_n = ~(req_reg.write & req_reg.lower_byte);
                    pins_next.upper_byte_we_n = ~(req_reg.write & req_reg.upper_byte);
                    cnt_next   = STROBE_LD;
                    state_next = dpc_pkg::DPC_STROBE;
                end
            end
            dpc_pkg::DPC_STROBE: begin
                // A low flag holds reads and writes in the strobe and reloads the hold count; a high flag lets the access run normally.
                if (!CONTENTION_FLAG_N_I) begin
                    seen_next    = 1'b1;
                    flagged_next = 1'b1;
                    cnt_next     = HOLD_LD;
                end else if (seen_reg && cnt_reg != dpc_pkg::CNT_ZERO) begin
                    // Flag released: keep strobing so the write lands after resolution.
                    cnt_next = cnt_reg - 4'h1;
                end else if (cnt_reg != dpc_pkg::CNT_ZERO) begin
                    cnt_next = cnt_reg - 4'h1;
                end else begin
                    rdata_next = DQ_I;
                    pins_next  = idle_pins(pins_reg.addr);
                    oe_next    = 1'b0;
                    state_next = dpc_pkg::DPC_DONE;
                end
            end
            dpc_pkg::DPC_DONE: begin
                done_next  = 1'b1;
                state_next = dpc_pkg::DPC_IDLE;
            end
            default: begin
                state_next = dpc_pkg::DPC_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            state_reg   <= dpc_pkg::DPC_IDLE;
            cnt_reg     <= dpc_pkg::CNT_ZERO;
            req_reg     <= '0;
            pins_reg    <= idle_pins('0);
            rdata_reg   <= '0;
            oe_reg      <= 1'b0;
            ready_reg   <= 1'b0;
            done_reg    <= 1'b0;
            flagged_reg <= 1'b0;
            seen_reg    <= 1'b0;
        end else begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            req_reg     <= req_next;
            pins_reg    <= pins_next;
            rdata_reg   <= rdata_next;
            oe_reg      <= oe_next;
            ready_reg   <= ready_next;
            done_reg    <= done_next;
            flagged_reg <= flagged_next;
            seen_reg    <= seen_next;
        end
    end

    assign REQ_READY_O = ready_reg;
    assign DONE_O      = done_reg;
    assign RDATA_O     = rdata_reg;
    // Per-access contention report that the system may OR into an interrupt.
    assign FLAGGED_O   = flagged_reg;
    assign PINS_O      = pins_reg;
    assign DQ_O        = req_reg.wdata;
    assign DQ_OE_O     = oe_reg;

    addr_stable_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        $changed(pins_reg.addr) |-> pins_reg.select_n || (pins_reg.lower_byte_we_n && pins_reg.upper_byte_we_n))
        else $error("Address changed during an active write window.");
    select_first_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        $fell(pins_reg.lower_byte_we_n) || $fell(pins_reg.upper_byte_we_n) |-> $past(!pins_reg.select_n))
        else $error("Write strobe fell without select already low.");
    idle_standby_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        state_reg == dpc_pkg::DPC_IDLE |-> pins_reg.select_n)
        else $error("Port selected while idle.");
    strobe_delay_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        $fell(pins_reg.select_n) |-> (pins_reg.lower_byte_we_n && pins_reg.upper_byte_we_n) [*2])
        else $error("Write strobe not delayed past arbitration time.");
    byte_strobe_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        !pins_reg.lower_byte_we_n |-> req_reg.write && req_reg.lower_byte)
        else $error("Lower byte strobe without a lower byte write.");
    write_hold_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        state_reg == dpc_pkg::DPC_STROBE && $rose(CONTENTION_FLAG_N_I) && seen_reg |-> state_reg == dpc_pkg::DPC_STROBE [*2])
        else $error("Write strobe released too soon after flag release.");
    data_drive_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        !pins_reg.lower_byte_we_n || !pins_reg.upper_byte_we_n |-> oe_reg && pins_reg.out_en_n)
        else $error("Data not driven during the write window.");
    done_follows_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        $rose(pins_reg.select_n) |=> done_reg)
        else $error("Done pulse missing after an access.");
endmodule : dpc_port_ctrl
`default_nettype wire

// ==== dpc_ram_model.sv ====
/* Behavioural dual-port RAM with contention logic: port A faces the controller, port B the bench.
   Assumes writes are sampled on the core clock edge and the flag pull-up is implied. */
`timescale 1ns/1ps
`default_nettype none
module dpc_ram_model (
    input  wire logic                       clk_i,
    input  wire dpc_pkg::dpc_pins_s         pins_i,
    input  wire logic [dpc_pkg::DATA_W-1:0] dq_i,
    output var  logic [dpc_pkg::DATA_W-1:0] dq_o,
    output var  logic                       flag_n_o,
    input  wire logic                       b_sel_n_i,
    input  wire logic [dpc_pkg::ADDR_W-1:0] b_addr_i,
    input  wire logic                       b_first_i
);
    logic [dpc_pkg::DATA_W-1:0] mem [0:2**dpc_pkg::ADDR_W-1];
    logic [dpc_pkg::DATA_W-1:0] last_reg = 16'h0000;
    logic                       match;
    logic                       rd;
    assign match = !pins_i.select_n && !b_sel_n_i && pins_i.addr == b_addr_i;
    // Port B wins when b_first_i is high and both ports select the same address; only port A has a flag, so it is the only side that can ever be flagged.
    assign flag_n_o = !(match && b_first_i);
    assign rd = !pins_i.select_n && !pins_i.out_en_n && pins_i.lower_byte_we_n && pins_i.upper_byte_we_n;
    // A released bus shows the inverse of its last value rather than a stale copy.
    assign dq_o = rd ? mem[pins_i.addr] : ~last_reg;
    always_ff @(posedge clk_i) begin
        last_reg <= dq_o;
        if (!pins_i.select_n && flag_n_o) begin
            if (!pins_i.lower_byte_we_n) mem[pins_i.addr][7:0] <= dq_i[7:0];
            if (!pins_i.upper_byte_we_n) mem[pins_i.addr][15:8] <= dq_i[15:8];
        end
    end
endmodule : dpc_ram_model
`default_nettype wire

// ==== tb.sv ====
/* Self-checking bench for the port controller against the behavioural RAM model.
   Assumes the design package and the RAM model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic               clk = 1'b0;
    logic               rstn = 1'b0;
    logic               valid = 1'b0;
    logic               b_sel_n = 1'b1;
    logic               b_first = 1'b0;
    logic [10:0]        b_addr = 11'h000;
    logic [10:0]        addr_prev = 11'h000;
    logic               flag_n, ready, done, flagged, dq_oe;
    logic [15:0]        rdata, dq_w, dq_r;
    dpc_pkg::dpc_req_s  req = '0;
    dpc_pkg::dpc_pins_s pins;
    int                 bad_count = 0;
    int                 checked = 0;
    int                 cycles = 0;
    initial forever #50 clk = ~clk;
    dpc_port_ctrl u_dut (.CORE_CLK_I(clk), .RSTN_I(rstn), .REQ_VALID_I(valid), .REQ_I(req), .REQ_READY_O(ready),
        .DONE_O(done), .RDATA_O(rdata), .FLAGGED_O(flagged), .PINS_O(pins), .DQ_I(dq_oe ? dq_w : dq_r),
        .DQ_O(dq_w), .DQ_OE_O(dq_oe), .CONTENTION_FLAG_N_I(flag_n));
    dpc_ram_model u_ram (.clk_i(clk), .pins_i(pins), .dq_i(dq_w), .dq_o(dq_r), .flag_n_o(flag_n),
        .b_sel_n_i(b_sel_n), .b_addr_i(b_addr), .b_first_i(b_first));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test
    // Address may only move while the port cannot be writing; pins are looked at once settled.
    always @(negedge clk) begin
        if (pins.addr !== addr_prev && !pins.select_n && !(pins.lower_byte_we_n && pins.upper_byte_we_n)) begin
            check("address hold", 16'h1, 16'h0);
        end
        addr_prev <= pins.addr;
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            stop_test();
        end
    end
    task automatic access(input logic wr, input logic lb, input logic ub, input logic [10:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(negedge clk);
        req = '{write: wr, lower_byte: lb, upper_byte: ub, addr: a, wdata: d};
        valid = 1'b1;
        while (ready !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        valid = 1'b0;
        while (done !== 1'b1 && n < 60) begin
            @(negedge clk);
            n++;
        end
        if (n >= 60) check("done", 16'h0, 16'h1);
    endtask : access
    task automatic t_word();
        access(1'b1, 1'b1, 1'b1, 11'h7ff, 16'ha55a);
        check("flag word", {15'h0, flagged}, 16'h0);
        access(1'b0, 1'b0, 1'b0, 11'h7ff, 16'h0000);
        check("read 7ff", rdata, 16'ha55a);
        $display("test word done");
    endtask : t_word
    task automatic t_bytes();
        access(1'b1, 1'b1, 1'b1, 11'h001, 16'h1234);
        access(1'b1, 1'b1, 1'b0, 11'h001, 16'habcd);
        access(1'b0, 1'b0, 1'b0, 11'h001, 16'h0000);
        check("lower byte", rdata, 16'h12cd);
        access(1'b1, 1'b0, 1'b1, 11'h001, 16'h5600);
        access(1'b0, 1'b0, 1'b0, 11'h001, 16'h0000);
        check("upper byte", rdata, 16'h56cd);
        $display("test bytes done");
    endtask : t_bytes
    // Port B holds the same or another location for a while, winning or losing arbitration.
    task automatic t_contend(input logic b_wins, input logic [10:0] ba);
        access(1'b1, 1'b1, 1'b1, 11'h010, 16'h0f0f);
        b_addr = ba;
        b_first = b_wins;
        b_sel_n = 1'b0;
        fork
            begin
                repeat (12) @(negedge clk);
                b_sel_n = 1'b1;
            end
        join_none
        access(1'b1, 1'b1, 1'b1, 11'h010, 16'hbeef);
        check("flagged", {15'h0, flagged}, {15'h0, b_wins && ba == 11'h010});
        access(1'b0, 1'b0, 1'b0, 11'h010, 16'h0000);
        check("after contention", rdata, 16'hbeef);
        $display("test contention done");
    endtask : t_contend
    initial begin
        repeat (2) @(negedge clk);
        check("select idle", {15'h0, pins.select_n}, 16'h1);
        rstn = 1'b1;
        t_word();
        t_bytes();
        t_contend(1'b1, 11'h010);
        t_contend(1'b0, 11'h010);
        t_contend(1'b1, 11'h011);
        stop_test();
    end
endmodule : tb
`default_nettype wire
